/* File: hw/sfsp_status_plane.sv */
// Operation
// - Primary log: flag bit 7, supplies bits 6-0.
// - Secondary log: watchdog bit 4, inputs 3-0.
// - Log bits reflect their function's logic state.
// - Flag sets on polarity change since read.
// - Flag set freezes both log registers.
// - Secondary read clears flag; primary read doesn't.
// - Both logs readable over the serial bus.
// - Mask bit holds log bit zero, no flag.
// - Masks mirror log layout; flag unmaskable.
// - Undervoltage status at D8, bits 6-0.
// - Overvoltage status at D9, bits 6-0.
// - Detector status at DA, bits 6-0.
// - Watchdog bit 4, inputs 3-0 at DB.
// - Driver outputs 8-1 at DE.
// - Driver output 9 at DF bit 0.
// - Status registers reset zero, read-only.
// - Status reads allowed anytime, no side effect.
// - Both logs reset to zero.
`timescale 1ns/1ps

module sfsp_status_plane (
	input wire logic SYS_CLK,
	input wire logic RSTN,
	input wire logic SCL,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE,
	input wire logic [6:0] UV_CMP,
	input wire logic [6:0] OV_CMP,
	input wire logic [6:0] SUPPLY_DET,
	input wire logic WATCHDOG_DET,
	input wire logic WATCHDOG_TIMEOUT,
	input wire logic [3:0] GEN_IN,
	input wire logic [8:0] DRV_OUT
);

	// ********************************************************************
	// Live status capture
	// ********************************************************************
	logic [6:0] uv_q;
	logic [6:0] ov_q;
	logic [6:0] det_q;
	logic [4:0] inwd_q;
	logic [8:0] drv_q;

	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			uv_q <= sfsp_pkg::STATUS_RESET[6:0];
			ov_q <= sfsp_pkg::STATUS_RESET[6:0];
			det_q <= sfsp_pkg::STATUS_RESET[6:0];
			inwd_q <= sfsp_pkg::STATUS_RESET[4:0];
			drv_q <= {sfsp_pkg::STATUS_RESET[0], sfsp_pkg::STATUS_RESET};
		end else begin
			uv_q <= UV_CMP;
			ov_q <= OV_CMP;
			det_q <= SUPPLY_DET;
			inwd_q <= {WATCHDOG_TIMEOUT, GEN_IN};
			drv_q <= DRV_OUT;
		end
	end

	// ********************************************************************
	// Fault plane
	// ********************************************************************
	logic [6:0] mask1_q;
	logic [4:0] mask2_q;
	logic [6:0] log1_q;
	logic [4:0] log2_q;
	logic [11:0] ref_q;
	logic any_q;
	logic rd2_pulse;

	wire [11:0] mask_all = {mask1_q, mask2_q};
	wire [11:0] func_live = {SUPPLY_DET, WATCHDOG_DET, GEN_IN};
	wire [11:0] func_masked = func_live & ~mask_all;
	wire [11:0] log_all = {log1_q, log2_q} & ~mask_all;
	wire change_seen = |((func_masked ^ ref_q) & ~mask_all);
	wire rd_change = |((func_masked ^ log_all) & ~mask_all);

	// The reference after a secondary read is the snapshot the controller has just seen,
	// so a change landing in the very read cycle keeps the flag set instead of vanishing.
	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			log1_q <= sfsp_pkg::FAULT_LOG_RESET[6:0];
			log2_q <= sfsp_pkg::FAULT_LOG_RESET[4:0];
			ref_q <= {sfsp_pkg::FAULT_LOG_RESET[6:0], sfsp_pkg::FAULT_LOG_RESET[4:0]};
			any_q <= 1'b0;
		end else if (rd2_pulse) begin
			{log1_q, log2_q} <= func_masked;
			ref_q <= log_all;
			any_q <= rd_change;
		end else if (!any_q) begin
			{log1_q, log2_q} <= func_masked;
			any_q <= change_seen;
		end
		// A set flag leaves the logs untouched until the secondary read.
	end

	// ********************************************************************
	// Serial bus pin conditioning
	// ********************************************************************
	logic [2:0] scl_sync_q;
	logic [2:0] sda_sync_q;
	logic scl_q;
	logic sda_q;

	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			scl_sync_q <= 3'h7;
			sda_sync_q <= 3'h7;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_sync_q <= {scl_sync_q[1:0], SCL};
			sda_sync_q <= {sda_sync_q[1:0], SDA_I};
			if (scl_sync_q[1] == scl_sync_q[2])
				scl_q <= scl_sync_q[2];
			if (sda_sync_q[1] == sda_sync_q[2])
				sda_q <= sda_sync_q[2];
		end
	end

	wire scl_new = (scl_sync_q[1] == scl_sync_q[2]) ? scl_sync_q[2] : scl_q;
	wire sda_new = (sda_sync_q[1] == sda_sync_q[2]) ? sda_sync_q[2] : sda_q;
	wire scl_rise = scl_new & ~scl_q;
	wire scl_fall = ~scl_new & scl_q;
	wire bus_start = scl_q & scl_new & sda_q & ~sda_new;
	wire bus_stop = scl_q & scl_new & ~sda_q & sda_new;

	// ********************************************************************
	// Register read selection
	// ********************************************************************
	function automatic logic [7:0] read_reg(input logic [7:0] ofs, input logic [6:0] uv, input logic [6:0] ov,
		input logic [6:0] det, input logic [4:0] inwd, input logic [8:0] drv, input logic [7:0] fl1,
		input logic [7:0] fl2, input logic [6:0] m1, input logic [4:0] m2);
		logic [7:0] r;
		r = 8'h00;
		unique case (ofs)
			sfsp_pkg::UNDERVOLTAGE_STATUS_OFS: r = {1'b0, uv};
			sfsp_pkg::OVERVOLTAGE_STATUS_OFS: r = {1'b0, ov};
			sfsp_pkg::SUPPLY_DETECTOR_STATUS_OFS: r = {1'b0, det};
			sfsp_pkg::INPUT_WATCHDOG_STATUS_OFS: r = {3'h0, inwd};
			sfsp_pkg::FAULT_LOG_PRIMARY_OFS: r = fl1;
			sfsp_pkg::FAULT_LOG_SECONDARY_OFS: r = fl2;
			sfsp_pkg::DRIVER_OUTPUT_STATUS_LOW_OFS: r = drv[7:0];
			sfsp_pkg::DRIVER_OUTPUT_STATUS_HIGH_OFS: r = {7'h00, drv[8]};
			sfsp_pkg::ERROR_MASK_PRIMARY_OFS: r = {1'b0, m1};
			sfsp_pkg::ERROR_MASK_SECONDARY_OFS: r = {3'h0, m2};
			default: r = 8'h00;
		endcase
		return r;
	endfunction

	logic [7:0] ptr_q;
	wire [7:0] fault_log_primary = {any_q, log_all[11:5]};
	wire [7:0] fault_log_secondary = {3'h0, log_all[4:0]};
	wire [7:0] rd_byte = read_reg(ptr_q, uv_q, ov_q, det_q, inwd_q, drv_q, fault_log_primary,
		fault_log_secondary, mask1_q, mask2_q);

	// ********************************************************************
	// Serial bus slave
	// ********************************************************************
	sfsp_pkg::sfsp_state_t state_q;
	logic [3:0] cnt_q;
	logic [7:0] shr_q;
	logic [7:0] tx_q;
	logic rw_q;
	logic nack_q;

	wire byte_done = scl_fall && (cnt_q == sfsp_pkg::BITS_PER_BYTE);
	// A sent byte ends at its eighth fall, because the ninth clock carries the master's acknowledge.
	wire tx_done = scl_fall && (cnt_q == sfsp_pkg::BITS_PER_BYTE - 4'h1);
	wire addr_hit = (shr_q[7:1] == sfsp_pkg::DEVICE_ADDRESS);
	wire load_tx = scl_fall && ((state_q == sfsp_pkg::SFSP_ADDR_ACK && rw_q) ||
		(state_q == sfsp_pkg::SFSP_RDATA_ACK && !nack_q));
	wire in_rx = (state_q == sfsp_pkg::SFSP_ADDR) || (state_q == sfsp_pkg::SFSP_CMD) ||
		(state_q == sfsp_pkg::SFSP_WDATA);
	wire in_ack = (state_q == sfsp_pkg::SFSP_ADDR_ACK) || (state_q == sfsp_pkg::SFSP_CMD_ACK) ||
		(state_q == sfsp_pkg::SFSP_WDATA_ACK);
	wire wr_strobe = byte_done && (state_q == sfsp_pkg::SFSP_WDATA);

	assign rd2_pulse = load_tx && (ptr_q == sfsp_pkg::FAULT_LOG_SECONDARY_OFS);

	// The line is open drain: the slave only ever pulls low.
	assign SDA_O = 1'b0;
	assign SDA_OE = in_ack || ((state_q == sfsp_pkg::SFSP_RDATA) && !tx_q[7]);

	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			state_q <= sfsp_pkg::SFSP_IDLE;
			cnt_q <= 4'h0;
			shr_q <= 8'h00;
			rw_q <= 1'b0;
			nack_q <= 1'b0;
		end else if (bus_start) begin
			state_q <= sfsp_pkg::SFSP_ADDR;
			cnt_q <= 4'h0;
		end else if (bus_stop) begin
			state_q <= sfsp_pkg::SFSP_IDLE;
		end else begin
			if (scl_rise && in_rx) begin
				shr_q <= {shr_q[6:0], sda_new};
				cnt_q <= cnt_q + 4'h1;
			end
			if (scl_rise && state_q == sfsp_pkg::SFSP_RDATA_ACK)
				nack_q <= sda_new;
			if (scl_fall && state_q == sfsp_pkg::SFSP_RDATA)
				cnt_q <= cnt_q + 4'h1;
			unique case (state_q)
				sfsp_pkg::SFSP_IDLE: begin
				end
				sfsp_pkg::SFSP_ADDR: if (byte_done) begin
					rw_q <= shr_q[0];
					state_q <= addr_hit ? sfsp_pkg::SFSP_ADDR_ACK : sfsp_pkg::SFSP_IDLE;
				end
				sfsp_pkg::SFSP_CMD: if (byte_done) begin
					state_q <= sfsp_pkg::SFSP_CMD_ACK;
				end
				sfsp_pkg::SFSP_WDATA: if (byte_done) begin
					state_q <= sfsp_pkg::SFSP_WDATA_ACK;
				end
				sfsp_pkg::SFSP_ADDR_ACK: if (scl_fall) begin
					cnt_q <= 4'h0;
					state_q <= rw_q ? sfsp_pkg::SFSP_RDATA : sfsp_pkg::SFSP_CMD;
				end
				sfsp_pkg::SFSP_CMD_ACK, sfsp_pkg::SFSP_WDATA_ACK: if (scl_fall) begin
					cnt_q <= 4'h0;
					state_q <= sfsp_pkg::SFSP_WDATA;
				end
				sfsp_pkg::SFSP_RDATA: if (tx_done) begin
					state_q <= sfsp_pkg::SFSP_RDATA_ACK;
				end
				sfsp_pkg::SFSP_RDATA_ACK: if (scl_fall) begin
					cnt_q <= 4'h0;
					state_q <= nack_q ? sfsp_pkg::SFSP_IDLE : sfsp_pkg::SFSP_RDATA;
				end
			endcase
		end
	end

	// ********************************************************************
	// Pointer, transmit shifter and mask registers
	// ********************************************************************
	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			ptr_q <= 8'h00;
			tx_q <= 8'hFF;
		end else begin
			if (byte_done && state_q == sfsp_pkg::SFSP_CMD)
				ptr_q <= shr_q;
			if (load_tx)
				tx_q <= rd_byte;
			else if (scl_fall && state_q == sfsp_pkg::SFSP_RDATA)
				tx_q <= {tx_q[6:0], 1'b1};
		end
	end

	// Writes that land on read-only or unmapped offsets are acknowledged and dropped.
	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			mask1_q <= sfsp_pkg::ERROR_MASK_RESET[6:0];
			mask2_q <= sfsp_pkg::ERROR_MASK_RESET[4:0];
		end else if (wr_strobe) begin
			if (ptr_q == sfsp_pkg::ERROR_MASK_PRIMARY_OFS)
				mask1_q <= shr_q[6:0];
			if (ptr_q == sfsp_pkg::ERROR_MASK_SECONDARY_OFS)
				mask2_q <= shr_q[4:0];
		end
	end

	// ********************************************************************
	// Assertions
	// ********************************************************************
	sequence s_rd2_quiet;
		rd2_pulse && !rd_change;
	endsequence

	sequence s_flag_held;
		any_q && !rd2_pulse;
	endsequence

	a_flag_on_change: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		!any_q && change_seen && !rd2_pulse |=> any_q)
		else $error("fault flag missed a polarity change");

	a_logs_frozen: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		s_flag_held ##1 s_flag_held |-> $stable(log1_q) && $stable(log2_q))
		else $error("fault logs moved while flag set");

	a_rd2_clears_flag: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		s_rd2_quiet |=> !any_q ##1 (any_q == $past(change_seen)))
		else $error("secondary read did not clear flag");

	a_rd1_keeps_flag: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		load_tx && ptr_q == sfsp_pkg::FAULT_LOG_PRIMARY_OFS && any_q |=> any_q)
		else $error("primary read changed flag");

	a_mask_holds_zero: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		ptr_q == sfsp_pkg::FAULT_LOG_PRIMARY_OFS |-> (rd_byte[6:0] & mask1_q) == 7'h00)
		else $error("masked primary log bit reads one");

	a_mask_clears_secondary: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		ptr_q == sfsp_pkg::FAULT_LOG_SECONDARY_OFS |-> (rd_byte[4:0] & mask2_q) == 5'h00)
		else $error("masked secondary log bit reads one");

	a_status_tracks: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		##1 uv_q == $past(UV_CMP) && drv_q == $past(DRV_OUT))
		else $error("status register lags its source");

	a_reserved_zero: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		load_tx && ptr_q == sfsp_pkg::DRIVER_OUTPUT_STATUS_HIGH_OFS |=> tx_q[7:1] == 7'h00)
		else $error("reserved bits read nonzero");

	a_addr_acked: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		state_q == sfsp_pkg::SFSP_ADDR && byte_done && addr_hit && !bus_start && !bus_stop
		|=> state_q == sfsp_pkg::SFSP_ADDR_ACK && SDA_OE)
		else $error("own address not acknowledged");

	a_log_follows: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		!any_q && !rd2_pulse |=> {log1_q, log2_q} == $past(func_masked))
		else $error("idle log does not follow functions");

	a_rd2_rebases: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		rd2_pulse |=> ref_q == $past(log_all) && {log1_q, log2_q} == $past(func_masked))
		else $error("secondary read did not rebase the reference");

	a_reset_clears: assert property (@(posedge SYS_CLK)
		!RSTN |=> {uv_q, ov_q, det_q, inwd_q, drv_q} == 35'h0 && {log1_q, log2_q} == 12'h000 && !any_q)
		else $error("status or log not cleared by reset");

	a_sent_byte_len: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		state_q == sfsp_pkg::SFSP_RDATA && tx_done && !bus_start && !bus_stop
		|=> state_q == sfsp_pkg::SFSP_RDATA_ACK && !SDA_OE)
		else $error("sent byte not released after eight bits");

	a_nack_ends_read: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		state_q == sfsp_pkg::SFSP_RDATA_ACK && scl_fall && nack_q && !bus_start && !bus_stop
		|=> state_q == sfsp_pkg::SFSP_IDLE)
		else $error("read went on after master refusal");

endmodule

/* File: hw/sfsp_pkg.sv */
package sfsp_pkg;

	// ********************************************************************
	// Register offsets
	// ********************************************************************
	localparam logic [7:0] UNDERVOLTAGE_STATUS_OFS = 8'hD8;
	localparam logic [7:0] OVERVOLTAGE_STATUS_OFS = 8'hD9;
	localparam logic [7:0] SUPPLY_DETECTOR_STATUS_OFS = 8'hDA;
	localparam logic [7:0] INPUT_WATCHDOG_STATUS_OFS = 8'hDB;
	localparam logic [7:0] FAULT_LOG_PRIMARY_OFS = 8'hDC;
	localparam logic [7:0] FAULT_LOG_SECONDARY_OFS = 8'hDD;
	localparam logic [7:0] DRIVER_OUTPUT_STATUS_LOW_OFS = 8'hDE;
	localparam logic [7:0] DRIVER_OUTPUT_STATUS_HIGH_OFS = 8'hDF;
	localparam logic [7:0] ERROR_MASK_PRIMARY_OFS = 8'h9D;
	localparam logic [7:0] ERROR_MASK_SECONDARY_OFS = 8'h9E;

	// ********************************************************************
	// Field layout and reset values
	// ********************************************************************
	localparam int ANY_FAULT_BIT = 7;
	localparam int SUPPLY_COUNT = 7;
	localparam int SECONDARY_COUNT = 5;
	localparam int WATCHDOG_BIT = 4;
	localparam int GENERAL_INPUT_COUNT = 4;
	localparam int DRIVER_COUNT = 9;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] FAULT_LOG_RESET = 8'h00;
	localparam logic [7:0] ERROR_MASK_RESET = 8'h00;

	// The bus address is arbitrary; a real part would strap or program it.
	localparam logic [6:0] DEVICE_ADDRESS = 7'h34;

	// ********************************************************************
	// Serial bus timing and states
	// ********************************************************************
	localparam int SYS_CLK_PERIOD_NS = 40;
	localparam int LINK_CLK_PERIOD_NS = 320;
	localparam int LINK_HALF_CYCLES = LINK_CLK_PERIOD_NS / (2 * SYS_CLK_PERIOD_NS);
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	typedef enum logic [3:0] {
		SFSP_IDLE,
		SFSP_ADDR,
		SFSP_ADDR_ACK,
		SFSP_CMD,
		SFSP_CMD_ACK,
		SFSP_WDATA,
		SFSP_WDATA_ACK,
		SFSP_RDATA,
		SFSP_RDATA_ACK
	} sfsp_state_t;

endpackage

/* File: testbench/sfsp_ctrl_model.sv */
`timescale 1ns/1ps
// ****************
// Controller model
// ****************
// Each link clock phase lasts four system clocks, one more than the receiver filter needs to settle a level.
module sfsp_ctrl_model (
	input wire logic clk,
	output logic scl = 1'b1,
	output logic sda_pull_low = 1'b0,
	input wire logic sda
);
	localparam int Q = 80;
	logic [7:0] prev_p = 8'h00, prev_s = 8'h00;
	task automatic bit_io(input logic b, output logic r);
		sda_pull_low = ~b;
		#Q scl = 1'b1;
		#Q r = sda;
		#Q scl = 1'b0;
		#Q;
	endtask
	task automatic frame_start();
		sda_pull_low = 1'b0;
		#(2 * Q) scl = 1'b1;
		#(2 * Q) sda_pull_low = 1'b1;
		#(2 * Q) scl = 1'b0;
		#Q;
	endtask
	task automatic frame_stop();
		sda_pull_low = 1'b1;
		#Q scl = 1'b1;
		#(2 * Q) sda_pull_low = 1'b0;
	endtask
	task automatic byte_io(input logic [7:0] b, input logic tail, output logic [7:0] got, output logic nine);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], r);
			got = {got[6:0], r};
		end
		bit_io(tail, nine);
	endtask
	// One byte per frame: the device never advances its offset.
	task automatic xfer(input logic rd_op, input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] wdat,
		output logic [7:0] d, output logic ok);
		logic [7:0] junk;
		logic n0, n1, n2;
		@(posedge clk);
		#1;
		frame_start();
		byte_io({dev, 1'b0}, 1'b1, junk, n0);
		byte_io(ofs, 1'b1, junk, n1);
		if (rd_op) begin
			frame_start();
			byte_io({dev, 1'b1}, 1'b1, junk, n2);
			byte_io(8'hFF, 1'b1, d, junk[0]);
		end else begin
			byte_io(wdat, 1'b1, junk, n2);
		end
		frame_stop();
		ok = ~(n0 | n1 | n2);
	endtask
	// The master acknowledges the first byte, so the device sends the same offset once more.
	task automatic read_twice(input logic [7:0] ofs, output logic [7:0] d0, output logic [7:0] d1, output logic ok);
		logic [7:0] junk;
		logic n0, n1, n2;
		@(posedge clk);
		#1;
		frame_start();
		byte_io({sfsp_pkg::DEVICE_ADDRESS, 1'b0}, 1'b1, junk, n0);
		byte_io(ofs, 1'b1, junk, n1);
		frame_start();
		byte_io({sfsp_pkg::DEVICE_ADDRESS, 1'b1}, 1'b1, junk, n2);
		byte_io(8'hFF, 1'b0, d0, junk[0]);
		byte_io(8'hFF, 1'b1, d1, junk[0]);
		frame_stop();
		ok = ~(n0 | n1 | n2);
	endtask
	// The secondary log is read only behind a set flag, because that read clears it.
	task automatic poll(output logic [7:0] p, output logic [7:0] s, output logic [11:0] chg);
		logic ok;
		xfer(1'b1, sfsp_pkg::DEVICE_ADDRESS, 8'hDC, 8'h00, p, ok);
		s = prev_s;
		if (p[7]) begin
			xfer(1'b1, sfsp_pkg::DEVICE_ADDRESS, 8'hDD, 8'h00, s, ok);
		end
		chg = {p[6:0] ^ prev_p[6:0], s[4:0] ^ prev_s[4:0]};
		{prev_p, prev_s} = {p, s};
	endtask
endmodule

/* File: testbench/supply_fault_status_plane_tb_top.sv */
`timescale 1ns/1ps
// ****************
// Bench
// ****************
module supply_fault_status_plane_tb_top;
	logic sys_clk = 1'b0, rstn = 1'b0, wd_det = 1'b0, wd_to = 1'b0;
	logic [6:0] uv = 7'h00, ov = 7'h00, det = 7'h00;
	logic [3:0] gin = 4'h0;
	logic [8:0] drv = 9'h000;
	logic scl, pull_low, sda_o, sda_oe, sda, ok;
	logic [7:0] d, p, s;
	logic [11:0] chg;
	int bad_count = 0, total_checks = 0;
	// The line has a pull-up, so it is low only while some party pulls it.
	assign sda = ~((sda_oe & ~sda_o) | pull_low);
	always #20 sys_clk = ~sys_clk;
	sfsp_status_plane dut_u (.SYS_CLK(sys_clk), .RSTN(rstn), .SCL(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe),
		.UV_CMP(uv), .OV_CMP(ov), .SUPPLY_DET(det), .WATCHDOG_DET(wd_det), .WATCHDOG_TIMEOUT(wd_to),
		.GEN_IN(gin), .DRV_OUT(drv));
	sfsp_ctrl_model ctrl_u (.clk(sys_clk), .scl(scl), .sda_pull_low(pull_low), .sda(sda));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic rd(input logic [7:0] ofs, input logic [7:0] exp, input string what);
		repeat (3) @(posedge sys_clk);
		ctrl_u.xfer(1'b1, sfsp_pkg::DEVICE_ADDRESS, ofs, 8'h00, d, ok);
		check({7'h00, ok}, 8'h01, "ack");
		check(d, exp, what);
	endtask
	task automatic wr(input logic [7:0] ofs, input logic [7:0] v);
		ctrl_u.xfer(1'b0, sfsp_pkg::DEVICE_ADDRESS, ofs, v, d, ok);
		check({7'h00, ok}, 8'h01, "write ack");
	endtask
	task automatic at_reset();
		logic [7:0] ofs [10] = '{8'hD8, 8'hD9, 8'hDA, 8'hDB, 8'hDE, 8'hDF, 8'hDC, 8'hDD, 8'h9D, 8'h9E};
		for (int i = 0; i < 10; i++) begin
			rd(ofs[i], 8'h00, "reset");
		end
	endtask
	task automatic status_map(input logic [6:0] u, input logic [6:0] o, input logic [6:0] f, input logic t,
		input logic [3:0] g, input logic [8:0] v);
		@(posedge sys_clk) #1 {uv, ov, det, wd_to, gin, drv} = {u, o, f, t, g, v};
		rd(8'hD8, {1'b0, u}, "uv");
		rd(8'hD9, {1'b0, o}, "ov");
		rd(8'hDA, {1'b0, f}, "det");
		rd(8'hDB, {3'h0, t, g}, "wd");
		rd(8'hDE, v[7:0], "drv lo");
		rd(8'hDF, {7'h00, v[8]}, "drv hi");
	endtask
	task automatic refusals();
		wr(8'hD8, 8'hFF);
		rd(8'hD8, {1'b0, uv}, "read only");
		rd(8'hE0, 8'h00, "unmapped");
		ctrl_u.xfer(1'b1, sfsp_pkg::DEVICE_ADDRESS ^ 7'h01, 8'hD8, 8'h00, d, ok);
		check({7'h00, ok}, 8'h00, "foreign");
		ctrl_u.read_twice(8'hDE, p, s, ok);
		check({7'h00, ok}, 8'h01, "burst ack");
		check(p, drv[7:0], "burst first");
		check(s, drv[7:0], "burst again");
	endtask
	task automatic fault_plane();
		@(posedge sys_clk) #1 {det, gin, wd_det} = 12'h000;
		repeat (2) ctrl_u.xfer(1'b1, sfsp_pkg::DEVICE_ADDRESS, 8'hDD, 8'h00, d, ok);
		rd(8'hDC, 8'h00, "idle");
		@(posedge sys_clk) #1 det = 7'h08;
		ctrl_u.poll(p, s, chg);
		check(p, 8'h88, "first");
		check(chg[11:4], 8'h10, "changed");
		@(posedge sys_clk) #1 gin = 4'h1;
		rd(8'hDC, 8'h88, "second");
		@(posedge sys_clk) #1 det = 7'h00;
		rd(8'hDC, 8'h88, "frozen");
		rd(8'hDD, 8'h01, "snapshot");
		rd(8'hDC, 8'h80, "rebased");
		rd(8'hDD, 8'h01, "live");
		rd(8'hDC, 8'h00, "cleared");
		@(posedge sys_clk) #1 wd_det = 1'b1;
		rd(8'hDC, 8'h80, "watchdog");
		rd(8'hDD, 8'h11, "wd bit");
	endtask
	task automatic masking();
		wr(8'h9D, 8'h08);
		rd(8'h9D, 8'h08, "mask");
		@(posedge sys_clk) #1 det = 7'h08;
		rd(8'hDC, 8'h00, "masked");
		wr(8'h9E, 8'h10);
		rd(8'hDD, 8'h01, "wd masked");
		@(posedge sys_clk) #1 wd_det = 1'b0;
		rd(8'hDC, 8'h00, "no flag");
		wr(8'h9D, 8'hFF);
		@(posedge sys_clk) #1 gin = 4'h0;
		rd(8'hDC, 8'h80, "flag kept");
		rd(8'hDD, 8'h00, "gin");
	endtask
	initial begin
		repeat (4) @(posedge sys_clk);
		#1 rstn = 1'b1;
		at_reset();
		status_map(7'h55, 7'h2A, 7'h33, 1'b1, 4'hA, 9'h1A5);
		status_map(7'h2A, 7'h55, 7'h4C, 1'b0, 4'h5, 9'h05A);
		refusals();
		fault_plane();
		masking();
		print_verdict();
	end
	initial begin
		repeat (80000) @(posedge sys_clk);
		check(8'h00, 8'h01, "timeout");
		print_verdict();
	end
endmodule
